//--- hw/vlan_port_ingress_policy.sv
// Per-port VLAN ingress classification, filtering, GVRP gating and egress tagging
`timescale 1ns/1ps
`default_nettype none

module vlan_port_ingress_policy #(
    parameter int VID_W = 12                            // VLAN identifier width
) (
    input  wire logic               clock,              // 125 MHz clock
    input  wire logic               reset_n,            // Synchronous reset, active low
    input  wire logic               clk_en,             // Freezes all state while low
    // Register port
    input  wire logic [3:0]         reg_addr,           // Register offset
    input  wire logic [15:0]        reg_wdata,          // Write data
    input  wire logic               reg_wr,             // Write strobe
    input  wire logic               reg_rd,             // Read strobe
    output logic      [15:0]        reg_rdata,          // Read data, cycle after strobe
    // VLAN table lookups, combinational, same clock
    output logic      [VID_W-1:0]   memb_vid,           // VLAN looked up for a default VLAN write
    input  wire logic [1:0]         memb_wr_state,      // Membership of memb_vid
    output logic                    memb_add_untag,     // Pulse: add port to VLAN 1 untagged
    // Ingress frame descriptor
    input  wire logic               rx_valid,           // Frame descriptor valid
    input  wire logic               rx_tagged,          // Frame carried a VLAN tag
    input  wire logic [VID_W-1:0]   rx_vid,             // VLAN from the tag
    input  wire logic [1:0]         rx_kind,            // Frame class
    input  wire logic [1:0]         rx_memb,            // Membership of this port in rx VLAN
    input  wire logic               gvrp_global_en,     // Switch-wide GVRP enable
    output logic                    ing_valid,          // Verdict valid
    output logic                    ing_accept,         // Frame forwarded
    output logic                    ing_flood,          // Forwarded as non-member flood
    output logic      [VID_W-1:0]   ing_vid,            // Classified VLAN
    // GVRP registration from other ports
    input  wire logic               reg_in_valid,       // Registration request for this port
    input  wire logic [1:0]         reg_in_memb,        // Membership of this port in its VLAN
    output logic                    reg_out_valid,      // Registration applied to this port
    // Egress frame descriptor
    input  wire logic               tx_valid,           // Frame descriptor valid
    input  wire logic [VID_W-1:0]   tx_vid,             // Frame VLAN
    input  wire logic [1:0]         tx_memb,            // Membership of this port in tx VLAN
    output logic                    eg_valid,           // Verdict valid
    output logic                    eg_send,            // Frame transmitted
    output logic                    eg_tag,             // Transmit with tag
    // Priority queues
    input  wire logic [3:0]         q_pending,          // Non-empty queues, bit 3 highest
    output logic      [1:0]         q_grant,            // Queue to serve next
    output logic                    q_grant_valid       // Some queue is pending
);

    // Identifiers wider than a register word could not be read back
    if (VID_W < 2 || VID_W > 16) begin : g_vid_w_check
        $error("VID_W out of range");
    end

    typedef struct packed {
        logic             tagged_only;
        logic             filter_en;
        logic             gvrp_en;
        logic             tagged_link;
        logic [VID_W-1:0] default_vid;
        logic [15:0]      join_t;
        logic [15:0]      leave_t;
        logic [15:0]      leaveall_t;
        logic             last_refused;
        logic [15:0]      rdata;
        logic             add_untag;
        logic             ing_valid;
        logic             ing_accept;
        logic             ing_flood;
        logic [VID_W-1:0] ing_vid;
        logic             reg_out_valid;
        logic             eg_valid;
        logic             eg_send;
        logic             eg_tag;
        logic [1:0]       q_grant;
        logic             q_grant_valid;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // Both ordering and range checks in one place
    function automatic logic timers_ok(input logic [15:0] j, input logic [15:0] l, input logic [15:0] la);
        logic [16:0] twice;
        twice = {j, 1'b0};
        return in_range(j, vlan_policy_pkg::JOIN_MIN, vlan_policy_pkg::JOIN_MAX)
            && in_range(l, vlan_policy_pkg::LEAVE_MIN, vlan_policy_pkg::LEAVE_MAX)
            && in_range(la, vlan_policy_pkg::LEAVEALL_MIN, vlan_policy_pkg::LEAVEALL_MAX)
            && (twice < {1'b0, l}) && (l < la);
    endfunction

    logic [VID_W-1:0] one_vid;
    logic             port_gvrp_on;
    logic [VID_W-1:0] wr_vid;
    logic [15:0]      cand_j;
    logic [15:0]      cand_l;
    logic [15:0]      cand_la;

    assign one_vid      = VID_W'(vlan_policy_pkg::DEFAULT_VID_RESET);
    assign port_gvrp_on = st_ff.gvrp_en & gvrp_global_en;
    assign wr_vid       = reg_wdata[VID_W-1:0];
    assign memb_vid     = wr_vid;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.add_untag     = 1'b0;
        nxt_st.ing_valid     = 1'b0;
        nxt_st.ing_accept    = 1'b0;
        nxt_st.ing_flood     = 1'b0;
        nxt_st.reg_out_valid = 1'b0;
        nxt_st.eg_valid      = 1'b0;
        nxt_st.eg_send       = 1'b0;
        nxt_st.eg_tag        = 1'b0;
        cand_j  = st_ff.join_t;
        cand_l  = st_ff.leave_t;
        cand_la = st_ff.leaveall_t;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                vlan_policy_pkg::REG_CTRL: begin
                    nxt_st.tagged_only = reg_wdata[vlan_policy_pkg::CTRL_TAGGED_ONLY];
                    nxt_st.filter_en   = reg_wdata[vlan_policy_pkg::CTRL_FILTER_EN];
                    nxt_st.gvrp_en     = reg_wdata[vlan_policy_pkg::CTRL_GVRP_EN];
                    nxt_st.tagged_link = reg_wdata[vlan_policy_pkg::CTRL_TAGGED_LINK];
                end
                vlan_policy_pkg::REG_DEFAULT_VID: begin
                    if (wr_vid == one_vid) begin
                        nxt_st.default_vid  = wr_vid;
                        nxt_st.last_refused = 1'b0;
                        nxt_st.add_untag    = (memb_wr_state == vlan_policy_pkg::MEMB_NONE)
                                            || (memb_wr_state == vlan_policy_pkg::MEMB_FORBIDDEN);
                    end else if (memb_wr_state == vlan_policy_pkg::MEMB_UNTAGGED) begin
                        nxt_st.default_vid  = wr_vid;
                        nxt_st.last_refused = 1'b0;
                    end else begin
                        nxt_st.last_refused = 1'b1;
                    end
                end
                vlan_policy_pkg::REG_JOIN:     cand_j  = reg_wdata;
                vlan_policy_pkg::REG_LEAVE:    cand_l  = reg_wdata;
                vlan_policy_pkg::REG_LEAVEALL: cand_la = reg_wdata;
                default: ;
            endcase
            if (reg_addr == vlan_policy_pkg::REG_JOIN || reg_addr == vlan_policy_pkg::REG_LEAVE
                    || reg_addr == vlan_policy_pkg::REG_LEAVEALL) begin
                // Whole-set check so a lone write cannot break the ordering
                if (timers_ok(cand_j, cand_l, cand_la)) begin
                    nxt_st.join_t       = cand_j;
                    nxt_st.leave_t      = cand_l;
                    nxt_st.leaveall_t   = cand_la;
                    nxt_st.last_refused = 1'b0;
                end else begin
                    nxt_st.last_refused = 1'b1;
                end
            end
        end

        // Register reads, data in the following cycle only
        nxt_st.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                vlan_policy_pkg::REG_CTRL:
                    nxt_st.rdata = {12'h000, st_ff.tagged_link, st_ff.gvrp_en, st_ff.filter_en, st_ff.tagged_only};
                vlan_policy_pkg::REG_DEFAULT_VID: nxt_st.rdata = 16'(st_ff.default_vid);
                vlan_policy_pkg::REG_JOIN:     nxt_st.rdata = st_ff.join_t;
                vlan_policy_pkg::REG_LEAVE:    nxt_st.rdata = st_ff.leave_t;
                vlan_policy_pkg::REG_LEAVEALL: nxt_st.rdata = st_ff.leaveall_t;
                vlan_policy_pkg::REG_STATUS:   nxt_st.rdata = {14'h0000, port_gvrp_on, st_ff.last_refused};
                default:                       nxt_st.rdata = 16'h0000;
            endcase
        end

        // Ingress verdict
        if (rx_valid) begin
            nxt_st.ing_valid = 1'b1;
            nxt_st.ing_vid   = rx_tagged ? rx_vid : st_ff.default_vid;
            if (!rx_tagged && st_ff.tagged_only) begin
                nxt_st.ing_accept = 1'b0;
            end else if (rx_kind == vlan_policy_pkg::FR_GVRP && !port_gvrp_on) begin
                nxt_st.ing_accept = 1'b0;
            end else if (rx_kind == vlan_policy_pkg::FR_GVRP || rx_kind == vlan_policy_pkg::FR_STP) begin
                nxt_st.ing_accept = 1'b1;
            end else if (!rx_tagged) begin
                nxt_st.ing_accept = 1'b1;
            end else if (rx_memb == vlan_policy_pkg::MEMB_TAGGED || rx_memb == vlan_policy_pkg::MEMB_UNTAGGED) begin
                nxt_st.ing_accept = 1'b1;
            end else if (st_ff.filter_en) begin
                nxt_st.ing_accept = 1'b0;
            end else begin
                // Forbidden VLANs are never flooded
                nxt_st.ing_accept = (rx_memb != vlan_policy_pkg::MEMB_FORBIDDEN);
                nxt_st.ing_flood  = (rx_memb != vlan_policy_pkg::MEMB_FORBIDDEN);
            end
        end

        // GVRP registrations arriving from other ports
        nxt_st.reg_out_valid = reg_in_valid && port_gvrp_on
                             && (reg_in_memb != vlan_policy_pkg::MEMB_FORBIDDEN);

        // Egress tagging
        if (tx_valid) begin
            nxt_st.eg_valid = 1'b1;
            unique case (tx_memb)
                vlan_policy_pkg::MEMB_TAGGED: begin
                    nxt_st.eg_send = 1'b1;
                    nxt_st.eg_tag  = !(st_ff.tagged_link && tx_vid == st_ff.default_vid);
                end
                vlan_policy_pkg::MEMB_UNTAGGED: begin
                    nxt_st.eg_send = 1'b1;
                    nxt_st.eg_tag  = 1'b0;
                end
                default: begin
                    nxt_st.eg_send = 1'b0;
                    nxt_st.eg_tag  = 1'b0;
                end
            endcase
        end

        // Strict priority, highest pending queue wins
        nxt_st.q_grant_valid = |q_pending;
        nxt_st.q_grant       = q_pending[3] ? 2'h3 : q_pending[2] ? 2'h2 : q_pending[1] ? 2'h1 : 2'h0;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_ff             <= '0;
            st_ff.tagged_only <= vlan_policy_pkg::CTRL_RESET[vlan_policy_pkg::CTRL_TAGGED_ONLY];
            st_ff.filter_en   <= vlan_policy_pkg::CTRL_RESET[vlan_policy_pkg::CTRL_FILTER_EN];
            st_ff.gvrp_en     <= vlan_policy_pkg::CTRL_RESET[vlan_policy_pkg::CTRL_GVRP_EN];
            st_ff.tagged_link <= vlan_policy_pkg::CTRL_RESET[vlan_policy_pkg::CTRL_TAGGED_LINK];
            st_ff.default_vid <= VID_W'(vlan_policy_pkg::DEFAULT_VID_RESET);
            st_ff.join_t      <= vlan_policy_pkg::JOIN_RESET;
            st_ff.leave_t     <= vlan_policy_pkg::LEAVE_RESET;
            st_ff.leaveall_t  <= vlan_policy_pkg::LEAVEALL_RESET;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata      = st_ff.rdata;
    assign memb_add_untag = st_ff.add_untag;
    assign ing_valid      = st_ff.ing_valid;
    assign ing_accept     = st_ff.ing_accept;
    assign ing_flood      = st_ff.ing_flood;
    assign ing_vid        = st_ff.ing_vid;
    assign reg_out_valid  = st_ff.reg_out_valid;
    assign eg_valid       = st_ff.eg_valid;
    assign eg_send        = st_ff.eg_send;
    assign eg_tag         = st_ff.eg_tag;
    assign q_grant        = st_ff.q_grant;
    assign q_grant_valid  = st_ff.q_grant_valid;

endmodule

`default_nettype wire

//--- hw/vlan_policy_pkg.sv
// Constants and types for the per-port VLAN ingress and egress policy block
package vlan_policy_pkg;

    localparam logic [11:0] DEFAULT_VID_RESET = 12'h001;
    localparam logic [15:0] JOIN_MIN        = 16'h0014;
    localparam logic [15:0] JOIN_MAX        = 16'h03e8;
    localparam logic [15:0] JOIN_RESET      = 16'h0014;
    localparam logic [15:0] LEAVE_MIN       = 16'h003c;
    localparam logic [15:0] LEAVE_MAX       = 16'h0bb8;
    localparam logic [15:0] LEAVE_RESET     = 16'h003c;
    localparam logic [15:0] LEAVEALL_MIN    = 16'h01f4;
    localparam logic [15:0] LEAVEALL_MAX    = 16'h4650;
    localparam logic [15:0] LEAVEALL_RESET  = 16'h03e8;

    // Register offsets of the plain command port
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_DEFAULT_VID = 4'h1;
    localparam logic [3:0] REG_JOIN     = 4'h2;
    localparam logic [3:0] REG_LEAVE    = 4'h3;
    localparam logic [3:0] REG_LEAVEALL = 4'h4;
    localparam logic [3:0] REG_STATUS   = 4'h5;

    // Control register bit positions
    localparam int CTRL_TAGGED_ONLY = 0;
    localparam int CTRL_FILTER_EN   = 1;
    localparam int CTRL_GVRP_EN     = 2;
    localparam int CTRL_TAGGED_LINK = 3;
    localparam logic [3:0] CTRL_RESET = 4'h4;

    localparam int NUM_QUEUES = 4;

    // Membership of this port in one VLAN
    typedef enum logic [1:0] {
        MEMB_NONE,
        MEMB_TAGGED,
        MEMB_UNTAGGED,
        MEMB_FORBIDDEN
    } memb_t;

    // Frame class as seen by the ingress parser
    typedef enum logic [1:0] {
        FR_DATA,
        FR_GVRP,
        FR_STP,
        FR_GMRP
    } frame_kind_t;

endpackage

//--- testbench/vlan_policy_assertions.sv
// Port-level concurrent checks for the VLAN port policy block
`timescale 1ns/1ps
`default_nettype none
module vlan_policy_checker (
    input wire logic       clock,          // Clock
    input wire logic       reset_n,        // Reset, active low
    input wire logic       clk_en,         // Run enable
    input wire logic       rx_valid,       // Ingress frame
    input wire logic       rx_tagged,      // Tag present
    input wire logic [1:0] rx_kind,        // Frame class
    input wire logic [1:0] rx_memb,        // Ingress membership
    input wire logic       gvrp_global_en, // Switch GVRP enable
    input wire logic       ing_accept,     // Forwarded
    input wire logic       ing_flood,      // Flooded
    input wire logic       reg_in_valid,   // Registration in
    input wire logic [1:0] reg_in_memb,    // Its membership
    input wire logic       reg_out_valid,  // Registration applied
    input wire logic       tx_valid,       // Egress frame
    input wire logic [1:0] tx_memb,        // Egress membership
    input wire logic       eg_send,        // Sent
    input wire logic       eg_tag,         // Sent tagged
    input wire logic [3:0] q_pending,      // Pending queues
    input wire logic [1:0] q_grant,        // Granted queue
    input wire logic       memb_add_untag  // VLAN 1 add pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Only tagged frames, so the acceptable-frame setting never masks a verdict
    wire logic rx_go = rx_valid && clk_en && rx_tagged;
    wire logic tx_go = tx_valid && clk_en;

    AST_STP_PASS: assert property (rx_go && rx_kind == 2'h2 |=> ing_accept)
        else $error("Tagged STP frame dropped");
    AST_GVRP_OFF: assert property (rx_go && rx_kind == 2'h1 && !gvrp_global_en |=> !ing_accept)
        else $error("GVRP frame passed with GVRP off");
    AST_MEMBER_PASS: assert property (
        rx_go && rx_kind == 2'h0 && rx_memb inside {2'h1, 2'h2} |=> ing_accept && !ing_flood)
        else $error("Member frame not forwarded plainly");
    AST_FORBID_DROP: assert property (
        rx_go && rx_kind inside {2'h0, 2'h3} && rx_memb == 2'h3 |=> !ing_accept)
        else $error("Forbidden VLAN frame forwarded");
    AST_FLOOD_CAUSE: assert property (
        rx_valid && clk_en ##1 ing_flood |-> $past(rx_tagged) && $past(rx_memb) == 2'h0)
        else $error("Flood without tagged non-member frame");
    AST_REG_BLOCK: assert property (
        reg_in_valid && clk_en && (reg_in_memb == 2'h3 || !gvrp_global_en) |=> !reg_out_valid)
        else $error("Registration applied while blocked");
    AST_EG_NONMEMBER: assert property (tx_go && tx_memb inside {2'h0, 2'h3} |=> !eg_send)
        else $error("Frame sent on non-member port");
    AST_EG_UNTAG: assert property (tx_go && tx_memb == 2'h2 |=> eg_send && !eg_tag)
        else $error("Untagged member frame not sent bare");
    AST_Q_TOP: assert property (clk_en && q_pending[3] |=> q_grant == 2'h3)
        else $error("Top queue not granted first");

    cover property (rx_go ##1 ing_flood);
    cover property (memb_add_untag);
    cover property (tx_go ##1 eg_tag);
endmodule

bind vlan_port_ingress_policy vlan_policy_checker u_chk (
    .clock, .reset_n, .clk_en, .rx_valid, .rx_tagged, .rx_kind, .rx_memb, .gvrp_global_en, .ing_accept,
    .ing_flood, .reg_in_valid, .reg_in_memb, .reg_out_valid, .tx_valid, .tx_memb, .eg_send, .eg_tag,
    .q_pending, .q_grant, .memb_add_untag);
`default_nettype wire

//--- testbench/vlan_table_model.sv
// Far-side model answering membership lookups for default VLAN writes
`timescale 1ns/1ps
`default_nettype none
module vlan_table_model (
    input  wire logic [11:0] memb_vid,      // VLAN asked about
    output logic      [1:0]  memb_wr_state  // Membership answer
);
    // Fixed map: VLAN 1 none, 2 forbidden, 4 tagged, 3 and 7 untagged
    assign memb_wr_state = memb_vid[1:0] ^ 2'h1;
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the VLAN port policy block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock, reset_n, clk_en, reg_wr, reg_rd, rx_valid, rx_tagged, gvrp_global_en, reg_in_valid;
    logic        tx_valid, memb_add_untag, ing_valid, ing_accept, ing_flood, reg_out_valid, ok, act;
    logic        eg_valid, eg_send, eg_tag, q_grant_valid;
    logic [3:0]  reg_addr, q_pending, ctrl, a;
    logic [15:0] reg_wdata, reg_rdata, d, tj, tl, ta;
    logic [11:0] memb_vid, rx_vid, tx_vid, ing_vid, def_vid, ev;
    logic [1:0]  memb_wr_state, rx_kind, rx_memb, reg_in_memb, tx_memb, q_grant, ei, qe;
    logic [5:0]  ex;
    int          err_count = 0, n_compared = 0, cyc = 0;
    logic [15:0] rst [8] = '{16'h0004, 16'h0001, 16'h0014, 16'h003c, 16'h03e8, 16'h0002, 16'h0000, 16'h0000};
    logic [19:0] corner [8] = '{20'h44650, 20'h44651, 20'h203e9, 20'h30bb8, 20'h203e8, 20'h20013,
                                20'h307d0, 20'h30bb9};
    logic [11:0] vids [5] = '{12'h004, 12'h002, 12'h001, 12'h003, 12'h007};

    vlan_port_ingress_policy #(.VID_W(12)) DUT (
        .clock, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .memb_vid,
        .memb_wr_state, .memb_add_untag, .rx_valid, .rx_tagged, .rx_vid, .rx_kind, .rx_memb,
        .gvrp_global_en, .ing_valid, .ing_accept, .ing_flood, .ing_vid, .reg_in_valid, .reg_in_memb,
        .reg_out_valid, .tx_valid, .tx_vid, .tx_memb, .eg_valid, .eg_send, .eg_tag, .q_pending,
        .q_grant, .q_grant_valid);
    vlan_table_model partner (.memb_vid, .memb_wr_state);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk_word(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        chk_word({15'h0, got}, {15'h0, exp});
    endtask
    task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= wd;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] ad, input logic [15:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk_word(reg_rdata, e);
    endtask

    // Whole triple is judged, so a lone legal value may still be refused
    function automatic logic tok(input logic [15:0] j, l, e);
        return j >= vlan_policy_pkg::JOIN_MIN && j <= vlan_policy_pkg::JOIN_MAX && l >= vlan_policy_pkg::LEAVE_MIN
            && l <= vlan_policy_pkg::LEAVE_MAX && e >= vlan_policy_pkg::LEAVEALL_MIN
            && e <= vlan_policy_pkg::LEAVEALL_MAX && 2 * j < l && l < e;
    endfunction
    function automatic logic [1:0] ing_exp(input logic tg, input logic [1:0] k, m, input logic ac);
        if (!tg && ctrl[0]) return 2'h0;
        if (k == 2'h1 && !ac) return 2'h0;
        if (k == 2'h1 || k == 2'h2 || !tg || m == 2'h1 || m == 2'h2) return 2'h2;
        if (ctrl[1] || m == 2'h3) return 2'h0;
        return 2'h3;
    endfunction
    function automatic logic [1:0] top(input logic [3:0] p);
        top = 2'h0;
        for (int i = 0; i < 4; i++) if (p[i]) top = 2'(i);
    endfunction

    initial begin
        {reset_n, reg_wr, reg_rd, rx_valid, rx_tagged, reg_in_valid, tx_valid} = '0;
        {reg_addr, reg_wdata, rx_vid, rx_kind, rx_memb, reg_in_memb, tx_vid, tx_memb, q_pending} = '0;
        {gvrp_global_en, clk_en, def_vid, ctrl} = {1'b1, 1'b1, 12'h001, 4'h4};
        {tj, tl, ta} = {vlan_policy_pkg::JOIN_RESET, vlan_policy_pkg::LEAVE_RESET, vlan_policy_pkg::LEAVEALL_RESET};
        void'($urandom(32'h030b));
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) rdchk(i == 7 ? 4'hf : 4'(i), rst[i]);
        for (int i = 0; i < 40; i++) begin
            a = i < 8 ? corner[i][19:16] : 4'h2 + 4'($urandom_range(0, 2));
            d = i < 8 ? corner[i][15:0] : 16'($urandom_range(10, 1010) * (a == 4'h2 ? 1 : a == 4'h3 ? 3 : 18));
            ok = tok(a == 4'h2 ? d : tj, a == 4'h3 ? d : tl, a == 4'h4 ? d : ta);
            wr(a, d);
            if (ok && a == 4'h2) tj = d;
            if (ok && a == 4'h3) tl = d;
            if (ok && a == 4'h4) ta = d;
            rdchk(vlan_policy_pkg::REG_STATUS, {15'h0001, !ok});
            rdchk(a, a == 4'h2 ? tj : a == 4'h3 ? tl : ta);
        end
        for (int i = 0; i < 5; i++) begin
            ok = vids[i] == 12'h001 || vids[i][1:0] == 2'h3;
            wr(vlan_policy_pkg::REG_DEFAULT_VID, {4'h0, vids[i]});
            #1 chk_bit(memb_add_untag, vids[i] == 12'h001);
            if (ok) def_vid = vids[i];
            rdchk(vlan_policy_pkg::REG_DEFAULT_VID, {4'h0, def_vid});
            rdchk(vlan_policy_pkg::REG_STATUS, {15'h0001, !ok});
        end
        for (int b = 0; b < 16; b++) begin
            ctrl = 4'(b);
            wr(vlan_policy_pkg::REG_CTRL, {12'h0, ctrl});
            rdchk(vlan_policy_pkg::REG_CTRL, {12'h0, ctrl});
            // Expectation is taken from the inputs sampled at this edge, before new ones land
            for (int i = 0; i <= 30; i++) begin
                @(posedge clock);
                // Frozen edge: every output, pulses included, keeps what the last enabled edge gave
                if (clk_en) begin
                    act = ctrl[2] & gvrp_global_en;
                    ei = ing_exp(rx_tagged, rx_kind, rx_memb, act);
                    ev = rx_tagged ? rx_vid : def_vid;
                    qe = top(q_pending);
                    ex = {rx_valid, tx_valid, tx_valid && tx_memb inside {2'h1, 2'h2},
                          tx_valid && tx_memb == 2'h1 && !(ctrl[3] && tx_vid == def_vid),
                          reg_in_valid && act && reg_in_memb != 2'h3, |q_pending};
                end
                clk_en <= i == 30 || $urandom_range(0, 7) != 0;
                rx_valid <= i < 30 && $urandom_range(0, 3) != 0;
                tx_valid <= i < 30 && $urandom_range(0, 1) != 0;
                reg_in_valid <= i < 30 && $urandom_range(0, 1) != 0;
                gvrp_global_en <= $urandom_range(0, 3) != 0;
                {rx_tagged, rx_kind, rx_memb, reg_in_memb, tx_memb, q_pending} <= 13'($urandom);
                rx_vid <= 12'($urandom);
                tx_vid <= $urandom_range(0, 1) != 0 ? def_vid : 12'($urandom);
                #1 chk_bit(ing_valid, ex[5]);
                if (ex[5]) chk_word({14'h0, ing_accept, ing_flood}, {14'h0, ei});
                if (ex[5]) chk_word({4'h0, ing_vid}, {4'h0, ev});
                chk_word({13'h0, eg_valid, eg_send, eg_tag}, {13'h0, ex[4:2]});
                chk_bit(reg_out_valid, ex[1]);
                chk_word({13'h0, q_grant_valid, q_grant}, {13'h0, ex[0], qe});
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
